// *** pkg/vscr_consts.vh ***
// Constants for the video switch configuration register bank
`ifndef VSCR_CONSTS_VH
`define VSCR_CONSTS_VH

// ****************************************************
// Register offsets
// ****************************************************
`define VSCR_OFS_HS_MODE 8'h00
`define VSCR_OFS_AUX_MODE 8'h01
`define VSCR_OFS_RX_SET 8'h10
`define VSCR_OFS_TERM_LO 8'h11
`define VSCR_OFS_TERM_HI 8'h12
`define VSCR_OFS_EQ_LO 8'h13
`define VSCR_OFS_EQ_HI 8'h14
`define VSCR_OFS_TX_SET 8'h20

// ****************************************************
// Reset values
// ****************************************************
`define VSCR_RST_HS_MODE 8'h40
`define VSCR_RST_AUX_MODE 8'h40
`define VSCR_RST_RX_SET 8'h01
`define VSCR_RST_TERM 8'h00
`define VSCR_RST_EQ 8'h00
`define VSCR_RST_TX_SET 8'h03

// ****************************************************
// Writable bit masks, unused bits stay zero
// ****************************************************
`define VSCR_MASK_MODE 8'h43
`define VSCR_MASK_RX 8'h01
`define VSCR_MASK_LANE 8'hff
`define VSCR_MASK_TX 8'h0f

// ****************************************************
// Field positions
// ****************************************************
`define VSCR_EN_BIT 6
`define VSCR_SEL_MSB 1
`define VSCR_SEL_LSB 0
`define VSCR_TERM_MASTER_BIT 0
`define VSCR_PE_MSB 3
`define VSCR_PE_LSB 2
`define VSCR_PTO_BIT 1
`define VSCR_OCL_BIT 0

// ****************************************************
// Serial slave constants
// ****************************************************
`define VSCR_ADDR_HI 4'h9
`define VSCR_BYTE_BITS 4'h8

`endif

// *** core/vscr_regbank.v ***
// Register storage of the video switch configuration bank
`default_nettype none
`include "vscr_consts.vh"

module vscr_regbank (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Access port
  input wire wr_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_ff,
  // Stored settings
  output reg [7:0] hs_path_mode_ff,
  output reg [7:0] aux_path_mode_ff,
  output reg [7:0] receiver_settings_ff,
  output reg [7:0] input_term_lo_ff,
  output reg [7:0] input_term_hi_ff,
  output reg [7:0] input_eq_lo_ff,
  output reg [7:0] input_eq_hi_ff,
  output reg [7:0] transmitter_settings_ff
);

  // One-hot register select, zero for unmapped offsets
  function [7:0] vscr_sel;
    input [7:0] a;
    begin
      if (a == `VSCR_OFS_HS_MODE) vscr_sel = 8'h01;
      else if (a == `VSCR_OFS_AUX_MODE) vscr_sel = 8'h02;
      else if (a == `VSCR_OFS_RX_SET) vscr_sel = 8'h04;
      else if (a == `VSCR_OFS_TERM_LO) vscr_sel = 8'h08;
      else if (a == `VSCR_OFS_TERM_HI) vscr_sel = 8'h10;
      else if (a == `VSCR_OFS_EQ_LO) vscr_sel = 8'h20;
      else if (a == `VSCR_OFS_EQ_HI) vscr_sel = 8'h40;
      else if (a == `VSCR_OFS_TX_SET) vscr_sel = 8'h80;
      else vscr_sel = 8'h00;
    end
  endfunction

  wire [7:0] wsel = vscr_sel(addr);

  // Masked writes, unused bits never stored
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_path_mode_ff <= `VSCR_RST_HS_MODE;
      aux_path_mode_ff <= `VSCR_RST_AUX_MODE;
      receiver_settings_ff <= `VSCR_RST_RX_SET;
      input_term_lo_ff <= `VSCR_RST_TERM;
      input_term_hi_ff <= `VSCR_RST_TERM;
      input_eq_lo_ff <= `VSCR_RST_EQ;
      input_eq_hi_ff <= `VSCR_RST_EQ;
      transmitter_settings_ff <= `VSCR_RST_TX_SET;
    end else if (wr_en) begin
      if (wsel[0]) hs_path_mode_ff <= wdata & `VSCR_MASK_MODE;
      if (wsel[1]) aux_path_mode_ff <= wdata & `VSCR_MASK_MODE;
      if (wsel[2]) receiver_settings_ff <= wdata & `VSCR_MASK_RX;
      if (wsel[3]) input_term_lo_ff <= wdata & `VSCR_MASK_LANE;
      if (wsel[4]) input_term_hi_ff <= wdata & `VSCR_MASK_LANE;
      if (wsel[5]) input_eq_lo_ff <= wdata & `VSCR_MASK_LANE;
      if (wsel[6]) input_eq_hi_ff <= wdata & `VSCR_MASK_LANE;
      if (wsel[7]) transmitter_settings_ff <= wdata & `VSCR_MASK_TX;
    end
  end

  // Registered read data, unmapped offsets read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= ({8{wsel[0]}} & hs_path_mode_ff) | ({8{wsel[1]}} & aux_path_mode_ff) |
                  ({8{wsel[2]}} & receiver_settings_ff) | ({8{wsel[3]}} & input_term_lo_ff) |
                  ({8{wsel[4]}} & input_term_hi_ff) | ({8{wsel[5]}} & input_eq_lo_ff) |
                  ({8{wsel[6]}} & input_eq_hi_ff) | ({8{wsel[7]}} & transmitter_settings_ff);
    end
  end

endmodule // vscr_regbank
`default_nettype wire

// *** core/vscr_top.v ***
// Two-wire serial slave and configuration outputs of the video switch
//
// Notes on behaviour
// - Every register can be written and read back over the two-wire serial port.
// - Low three slave address bits come from three strap pins.
// - After any serial access that matches the slave address, parallel strap controls are ignored until reset.
// - Bit 6 at 0x00, reset 0x40, turns high-speed lanes on; zero is standby.
// - Bits 1:0 at 0x00 pick high-speed source A, B, C or D.
// - Bit 6 at 0x01, reset 0x40, closes the auxiliary switch; zero opens it.
// - Bits 1:0 at 0x01 pick auxiliary source A, B, C or D.
// - Bit 0 at 0x10 off opens all terminations; on, lanes follow own bits.
// - Sixteen lane termination bits at 0x11 and 0x12; one connects termination.
// - Bits 0-3 B, 4-7 A, 8-11 C3..C0, 12-15 D3..D0.
// - Lane equalization bits use same order; zero low, one high equalization.
// - Two-bit output emphasis for all lanes: none, low, medium, high.
// - Output termination bit for all lanes: zero off, one on.
// - Output current bit for all lanes: zero lower, one higher current.
`default_nettype none
`include "vscr_consts.vh"

module vscr_top (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Serial port, data line is open drain
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_ff,
  output reg sda_oe_ff,
  // Address straps
  input wire slave_addr_strap_2,
  input wire slave_addr_strap_1,
  input wire slave_addr_strap_0,
  // Parallel strap controls
  input wire par_en,
  input wire [1:0] par_sel,
  input wire par_eq,
  input wire [1:0] par_pre,
  input wire par_oto,
  input wire par_ocl,
  // Path controls
  output reg fast_path_on_ff,
  output reg [1:0] fast_source_sel_ff,
  output reg side_path_on_ff,
  output reg [1:0] side_source_sel_ff,
  // Lane controls, bit 4*source+lane, source A is 0
  output reg [15:0] input_term_lane_ff,
  output reg [15:0] input_eq_lane_ff,
  // Output driver controls
  output reg [1:0] out_emphasis_level_ff,
  output reg out_term_on_ff,
  output reg out_drive_level_ff,
  // Serial ownership status
  output reg serial_owned_ff
);

  // ****************************************************
  // Serial engine states
  // ****************************************************
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_ACK_A = 9'h004;
  localparam [8:0] ST_REG = 9'h008;
  localparam [8:0] ST_ACK_R = 9'h010;
  localparam [8:0] ST_WDATA = 9'h020;
  localparam [8:0] ST_ACK_W = 9'h040;
  localparam [8:0] ST_RDATA = 9'h080;
  localparam [8:0] ST_ACK_M = 9'h100;

  // Reorders a register bit vector into source-major lane order
  function [15:0] vscr_lane_order;
    input [15:0] v;
    integer i;
    begin
      vscr_lane_order = 16'h0000;
      for (i = 0; i < 4; i = i + 1) begin
        vscr_lane_order[i] = v[4 + i];
        vscr_lane_order[4 + i] = v[i];
        vscr_lane_order[8 + i] = v[11 - i];
        vscr_lane_order[12 + i] = v[15 - i];
      end
    end
  endfunction

  // ****************************************************
  // Reset release
  // ****************************************************
  reg rst_meta_ff;
  reg rst_n_ff;

  // Two-stage release of the asynchronous reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ****************************************************
  // Line sampling and bus conditions
  // ****************************************************
  reg scl_q_ff;
  reg sda_q_ff;
  reg scl_prev_ff;
  reg sda_prev_ff;

  // Sample lines and keep previous values for edge detection
  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
      scl_prev_ff <= scl_q_ff;
      sda_prev_ff <= sda_q_ff;
    end
  end

  wire scl_rise = scl_q_ff & ~scl_prev_ff;
  wire scl_fall = ~scl_q_ff & scl_prev_ff;
  wire start_det = scl_q_ff & scl_prev_ff & sda_prev_ff & ~sda_q_ff;
  wire stop_det = scl_q_ff & scl_prev_ff & ~sda_prev_ff & sda_q_ff;

  // ****************************************************
  // Slave address capture
  // ****************************************************
  reg strap_done_ff;
  reg [6:0] dev_addr_ff;

  // Straps are caught once, on the first edge after reset release
  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      strap_done_ff <= 1'b0;
      dev_addr_ff <= 7'h00;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      dev_addr_ff <= {`VSCR_ADDR_HI, slave_addr_strap_2, slave_addr_strap_1, slave_addr_strap_0};
    end
  end

  // ****************************************************
  // Serial engine
  // ****************************************************
  reg [8:0] state_ff;
  reg [8:0] nxt_state;
  reg [3:0] bitcnt_ff;
  reg [3:0] nxt_bitcnt;
  reg [7:0] shift_ff;
  reg [7:0] nxt_shift;
  reg [7:0] ptr_ff;
  reg [7:0] nxt_ptr;
  reg rw_ff;
  reg nxt_rw;
  reg nxt_sda_oe;
  reg nxt_serial_owned;
  reg bank_we;
  wire [7:0] bank_rdata;

  wire rx_bit = scl_rise && (bitcnt_ff != `VSCR_BYTE_BITS);
  wire byte_end = scl_fall && (bitcnt_ff == `VSCR_BYTE_BITS);
  wire [3:0] cnt_inc = bitcnt_ff + 4'h1;

  // Next state of the byte engine; stop and start override any state
  always @* begin
    nxt_state = state_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_rw = rw_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_serial_owned = serial_owned_ff;
    bank_we = 1'b0;
    if (stop_det) begin
      nxt_state = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (start_det) begin
      nxt_state = ST_ADDR;
      nxt_bitcnt = 4'h0;
      nxt_sda_oe = 1'b0;
    end else begin
      case (state_ff)
        ST_ADDR: begin
          if (rx_bit) begin
            nxt_shift = {shift_ff[6:0], sda_q_ff};
            nxt_bitcnt = cnt_inc;
          end else if (byte_end) begin
            nxt_bitcnt = 4'h0;
            if (strap_done_ff && (shift_ff[7:1] == dev_addr_ff)) begin
              nxt_state = ST_ACK_A;
              nxt_sda_oe = 1'b1;
              nxt_rw = shift_ff[0];
              nxt_serial_owned = 1'b1;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_REG, ST_WDATA: begin
          if (rx_bit) begin
            nxt_shift = {shift_ff[6:0], sda_q_ff};
            nxt_bitcnt = cnt_inc;
          end else if (byte_end) begin
            nxt_bitcnt = 4'h0;
            nxt_sda_oe = 1'b1;
            if (state_ff == ST_REG) begin
              nxt_ptr = shift_ff;
              nxt_state = ST_ACK_R;
            end else begin
              bank_we = 1'b1;
              nxt_state = ST_ACK_W;
            end
          end
        end
        ST_ACK_A, ST_ACK_M: begin
          if (state_ff == ST_ACK_M && scl_rise && sda_q_ff) begin
            nxt_state = ST_IDLE;
          end else if (scl_fall) begin
            nxt_bitcnt = 4'h0;
            if (rw_ff) begin
              nxt_state = ST_RDATA;
              nxt_sda_oe = ~bank_rdata[7];
              nxt_shift = {bank_rdata[6:0], 1'b0};
            end else begin
              nxt_state = ST_REG;
              nxt_sda_oe = 1'b0;
            end
          end
        end
        ST_ACK_R, ST_ACK_W: begin
          if (scl_fall) begin
            nxt_state = ST_WDATA;
            nxt_sda_oe = 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            nxt_bitcnt = cnt_inc;
          end else if (scl_fall) begin
            if (bitcnt_ff == `VSCR_BYTE_BITS) begin
              nxt_state = ST_ACK_M;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_sda_oe = ~shift_ff[7];
              nxt_shift = {shift_ff[6:0], 1'b0};
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Serial engine registers; ownership stays until reset
  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      serial_owned_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bitcnt_ff <= nxt_bitcnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      rw_ff <= nxt_rw;
      sda_oe_ff <= nxt_sda_oe;
      sda_out_ff <= 1'b0;
      serial_owned_ff <= nxt_serial_owned;
    end
  end

  // ****************************************************
  // Register storage
  // ****************************************************
  wire [7:0] hs_mode;
  wire [7:0] aux_mode;
  wire [7:0] rx_set;
  wire [7:0] term_lo;
  wire [7:0] term_hi;
  wire [7:0] eq_lo;
  wire [7:0] eq_hi;
  wire [7:0] tx_set;

  vscr_regbank u_bank (
    .clk(clk),
    .rst_n(rst_n_ff),
    .wr_en(bank_we),
    .addr(ptr_ff),
    .wdata(shift_ff),
    .rdata_ff(bank_rdata),
    .hs_path_mode_ff(hs_mode),
    .aux_path_mode_ff(aux_mode),
    .receiver_settings_ff(rx_set),
    .input_term_lo_ff(term_lo),
    .input_term_hi_ff(term_hi),
    .input_eq_lo_ff(eq_lo),
    .input_eq_hi_ff(eq_hi),
    .transmitter_settings_ff(tx_set)
  );

  // ****************************************************
  // Control outputs
  // ****************************************************
  wire [15:0] term_lanes = vscr_lane_order({term_hi, term_lo});
  wire [15:0] eq_lanes = vscr_lane_order({eq_hi, eq_lo});

  // Serial settings once owned, parallel straps before that, with side path forced on and input termination off
  always @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      fast_path_on_ff <= 1'b0;
      fast_source_sel_ff <= 2'h0;
      side_path_on_ff <= 1'b0;
      side_source_sel_ff <= 2'h0;
      input_term_lane_ff <= 16'h0000;
      input_eq_lane_ff <= 16'h0000;
      out_emphasis_level_ff <= 2'h0;
      out_term_on_ff <= 1'b0;
      out_drive_level_ff <= 1'b0;
    end else if (serial_owned_ff) begin
      fast_path_on_ff <= hs_mode[`VSCR_EN_BIT];
      fast_source_sel_ff <= hs_mode[`VSCR_SEL_MSB:`VSCR_SEL_LSB];
      side_path_on_ff <= aux_mode[`VSCR_EN_BIT];
      side_source_sel_ff <= aux_mode[`VSCR_SEL_MSB:`VSCR_SEL_LSB];
      input_term_lane_ff <= rx_set[`VSCR_TERM_MASTER_BIT] ? term_lanes : 16'h0000;
      input_eq_lane_ff <= eq_lanes;
      out_emphasis_level_ff <= tx_set[`VSCR_PE_MSB:`VSCR_PE_LSB];
      out_term_on_ff <= tx_set[`VSCR_PTO_BIT];
      out_drive_level_ff <= tx_set[`VSCR_OCL_BIT];
    end else begin
      fast_path_on_ff <= par_en;
      fast_source_sel_ff <= par_sel;
      side_path_on_ff <= 1'b1;
      side_source_sel_ff <= par_sel;
      input_term_lane_ff <= 16'h0000;
      input_eq_lane_ff <= {16{par_eq}};
      out_emphasis_level_ff <= par_pre;
      out_term_on_ff <= par_oto;
      out_drive_level_ff <= par_ocl;
    end
  end

endmodule // vscr_top
`default_nettype wire

// *** tb/vscr_top_sva.sv ***
// Assertion checker bound to the video switch configuration top
`default_nettype none
module vscr_top_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial lines
  input wire logic scl_in,
  input wire logic sda_out_ff,
  input wire logic sda_oe_ff,
  // Parallel strap controls
  input wire logic par_en,
  input wire logic [1:0] par_sel,
  input wire logic par_eq,
  input wire logic [1:0] par_pre,
  input wire logic par_oto,
  input wire logic par_ocl,
  // Control outputs
  input wire logic fast_path_on_ff,
  input wire logic [1:0] fast_source_sel_ff,
  input wire logic side_path_on_ff,
  input wire logic [1:0] side_source_sel_ff,
  input wire logic [15:0] input_term_lane_ff,
  input wire logic [15:0] input_eq_lane_ff,
  input wire logic [1:0] out_emphasis_level_ff,
  input wire logic out_term_on_ff,
  input wire logic out_drive_level_ff,
  input wire logic serial_owned_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] up_ff;
  logic [41:0] outs;

  // All control outputs in one vector for change detection
  assign outs = {fast_path_on_ff, fast_source_sel_ff, side_path_on_ff, side_source_sel_ff, input_term_lane_ff,
                 input_eq_lane_ff, out_emphasis_level_ff, out_term_on_ff, out_drive_level_ff};

  // Saturating count of cycles since reset release, masks the start-up latency
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_ff <= 3'h0;
    end else if (up_ff != 3'h7) begin
      up_ff <= up_ff + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  owned_sticky_a: assert property (serial_owned_ff |=> serial_owned_ff)
    else $error("serial ownership dropped before reset");
  owned_on_ack_a: assert property ($rose(serial_owned_ff) |-> sda_oe_ff && !scl_in)
    else $error("ownership taken without an address ack");
  sda_out_low_a: assert property (sda_oe_ff |-> !sda_out_ff)
    else $error("data line driven high");
  oe_rise_low_a: assert property ($rose(sda_oe_ff) |-> !scl_in)
    else $error("data line pulled while clock high");
  oe_hold_a: assert property ($rose(sda_oe_ff) |-> sda_oe_ff[*6])
    else $error("data line pull too short");
  par_path_a: assert property (up_ff == 3'h7 && !serial_owned_ff && !$past(serial_owned_ff) |->
      fast_path_on_ff == $past(par_en) && fast_source_sel_ff == $past(par_sel) && side_path_on_ff
      && side_source_sel_ff == $past(par_sel))
    else $error("path controls do not follow parallel pins");
  par_lane_a: assert property (up_ff == 3'h7 && !serial_owned_ff && !$past(serial_owned_ff) |->
      input_term_lane_ff == 16'h0000 && input_eq_lane_ff == {16{$past(par_eq)}}
      && out_emphasis_level_ff == $past(par_pre) && out_term_on_ff == $past(par_oto)
      && out_drive_level_ff == $past(par_ocl))
    else $error("lane controls do not follow parallel pins");
  owned_frozen_a: assert property (up_ff == 3'h7 && $past(serial_owned_ff, 2) && $changed(outs) |-> sda_oe_ff)
    else $error("controls changed outside a serial write");
endmodule // vscr_top_sva

bind vscr_top vscr_top_sva chk_i (.clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_out_ff(sda_out_ff),
  .sda_oe_ff(sda_oe_ff), .par_en(par_en), .par_sel(par_sel), .par_eq(par_eq), .par_pre(par_pre),
  .par_oto(par_oto), .par_ocl(par_ocl), .fast_path_on_ff(fast_path_on_ff), .fast_source_sel_ff(fast_source_sel_ff),
  .side_path_on_ff(side_path_on_ff), .side_source_sel_ff(side_source_sel_ff), .input_term_lane_ff(input_term_lane_ff),
  .input_eq_lane_ff(input_eq_lane_ff), .out_emphasis_level_ff(out_emphasis_level_ff),
  .out_term_on_ff(out_term_on_ff), .out_drive_level_ff(out_drive_level_ff), .serial_owned_ff(serial_owned_ff));
`default_nettype wire

// *** tb/vscr_master.sv ***
// Two-wire serial bus master model driving the configuration port
`default_nettype none
module vscr_master (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus: both lines released high, clock stands still
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Wait n falling clock edges, all changes land off the sampling edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Start or repeated start, waits out the slave's release after a fall
  task automatic start();
    sda_drv = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(6);
    sda_drv = 1'b0;
    tick(6);
    scl = 1'b0;
  endtask

  // Stop condition, leaves the bus idle
  task automatic stop();
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(6);
    sda_drv = 1'b1;
    tick(6);
  endtask

  // Nine bit slots MSB first, line sampled at the end of each high phase
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      tick(4);
      sda_drv = d[i];
      tick(4);
      scl = 1'b1;
      tick(6);
      r[i] = sda_line;
      scl = 1'b0;
    end
  endtask
endmodule // vscr_master
`default_nettype wire

// *** tb/video_switch_config_regs_tb.sv ***
// Self-checking bench for the video switch configuration register bank
`default_nettype none
module video_switch_config_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************
  // Signals and reference model
  // ****************************************************
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [7:0] par = 8'h00;
  logic [31:0] rng = 32'hdea83689;
  int errors = 0;
  int checked = 0;
  wire logic scl, sda_drv, sda_line, sda_out_ff, sda_oe_ff, fast_on, side_on, oterm, drive, owned;
  wire logic [1:0] fast_sel, side_sel, emph;
  wire logic [15:0] term, eq;
  logic [7:0] mdl [0:8];
  logic [7:0] ofs [0:8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h30};
  logic [7:0] msk [0:8] = '{8'h43, 8'h43, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h00};
  logic [7:0] dfl [0:8] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};

  // Open-drain data line with pull-up
  assign sda_line = sda_drv & ~(sda_oe_ff & ~sda_out_ff);

  // Clock
  initial begin
    forever #4 clk = ~clk;
  end

  vscr_top uut (.clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line), .sda_out_ff(sda_out_ff),
    .sda_oe_ff(sda_oe_ff), .slave_addr_strap_2(strap[2]), .slave_addr_strap_1(strap[1]),
    .slave_addr_strap_0(strap[0]), .par_en(par[0]), .par_sel(par[2:1]), .par_eq(par[3]), .par_pre(par[5:4]),
    .par_oto(par[6]), .par_ocl(par[7]), .fast_path_on_ff(fast_on), .fast_source_sel_ff(fast_sel),
    .side_path_on_ff(side_on), .side_source_sel_ff(side_sel), .input_term_lane_ff(term), .input_eq_lane_ff(eq),
    .out_emphasis_level_ff(emph), .out_term_on_ff(oterm), .out_drive_level_ff(drive), .serial_owned_ff(owned));

  vscr_master m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Register vector to lane order, lane output bit is 4*source+lane
  function automatic logic [15:0] lanes(input logic [15:0] v);
    for (int i = 0; i < 4; i++) begin
      lanes[4 + i] = v[i];
      lanes[i] = v[4 + i];
      lanes[11 - i] = v[8 + i];
      lanes[15 - i] = v[12 + i];
    end
  endfunction

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Byte from master, slave must acknowledge
  task automatic put(input logic [7:0] b);
    logic [8:0] r;
    m.xfer({b, 1'b1}, r);
    chk("ack", r[0], 1'b0);
  endtask

  task automatic reg_write(input int k, input logic [7:0] v);
    m.start();
    put({4'h9, strap, 1'b0});
    put(ofs[k]);
    put(~v); // Overwritten by the next byte, the offset does not advance
    put(v);
    m.stop();
    mdl[k] = v & msk[k];
  endtask

  task automatic reg_read(input int k);
    logic [8:0] r;
    m.start();
    put({4'h9, strap, 1'b0});
    put(ofs[k]);
    m.start();
    put({4'h9, strap, 1'b1});
    m.xfer({8'hff, 1'b0}, r);
    chk("rdata", r[8:1], mdl[k]);
    m.xfer({8'hff, 1'b1}, r);
    m.stop();
    chk("rdata_rpt", r[8:1], mdl[k]);
  endtask

  // New random parallel pins, then let the one-cycle latency pass
  task automatic new_par();
    par = 8'(xs());
    repeat (3) @(negedge clk);
  endtask

  task automatic par_check();
    chk("par_ctl", {fast_on, fast_sel, side_on, side_sel, emph, oterm, drive},
        {par[0], par[2:1], 1'b1, par[2:1], par[5:4], par[6], par[7]});
    chk("par_term", term, 16'h0000);
    chk("par_eq", eq, {16{par[3]}});
    chk("owned", owned, 1'b0);
  endtask

  task automatic out_check();
    chk("fast_on", fast_on, mdl[0][6]);
    chk("fast_sel", fast_sel, mdl[0][1:0]);
    chk("side_on", side_on, mdl[1][6]);
    chk("side_sel", side_sel, mdl[1][1:0]);
    chk("term", term, mdl[2][0] ? lanes({mdl[4], mdl[3]}) : 16'h0000);
    chk("eq", eq, lanes({mdl[6], mdl[5]}));
    chk("emph", emph, mdl[7][3:2]);
    chk("oterm", oterm, mdl[7][1]);
    chk("drive", drive, mdl[7][0]);
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    logic [8:0] r;
    logic [7:0] v;
    for (int ph = 0; ph < 2; ph++) begin
      @(negedge clk);
      arst_n = 1'b0;
      strap = 3'(xs());
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      for (int k = 0; k < 9; k++) mdl[k] = dfl[k];
      new_par();
      par_check();
      // Wrong slave address is left unanswered and leaves parallel control alive
      m.start();
      m.xfer({4'h9, ~strap, 1'b0, 1'b1}, r);
      chk("nak", r[0], 1'b1);
      m.stop();
      new_par();
      par_check();
      for (int k = 0; k < 9; k++) reg_read(k);
      chk("owned", owned, 1'b1);
      new_par();
      out_check();
      for (int p = 0; p < (ph == 0 ? 4 : 1); p++) begin
        for (int k = 0; k < 9; k++) begin
          v = 8'(xs());
          v[1:0] = 2'(p);
          reg_write(k, v);
          new_par();
          out_check();
        end
        for (int k = 0; k < 9; k++) reg_read(k);
      end
    end
    stop_test();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule // video_switch_config_regs_tb
`default_nettype wire
